/* File: logic/rf_cond_pkg.sv */
// shared constants and carriers for the rf signal conditioning block
package rf_cond_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_HPF_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PEAK_BW = 8'h04;
  localparam logic [7:0] OFS_DEFECT_BW = 8'h08;
  localparam logic [7:0] OFS_LOOP_CTRL = 8'h0C;
  localparam logic [7:0] OFS_MAX_PEAK = 8'h10;
  localparam logic [7:0] OFS_MIN_PEAK = 8'h14;
  localparam logic [7:0] OFS_AMPLITUDE = 8'h18;
  localparam logic [7:0] OFS_OFFSET = 8'h1C;
  localparam logic [7:0] OFS_GAIN = 8'h20;
  localparam logic [7:0] OFS_AMP_THR = 8'h24;
  localparam logic [7:0] OFS_INTEG_BW = 8'h28;
  localparam logic [7:0] OFS_GAIN_BOUNDS = 8'h2C;
  localparam logic [7:0] OFS_OFFSET_COMP = 8'h30;
  localparam logic [7:0] OFS_OFFSET_WIN = 8'h34;
  localparam logic [7:0] OFS_COMP_BOUNDS = 8'h38;
  // field positions
  localparam int HPF_CLEAR_BIT = 6;
  localparam int INV_BIT = 16;
  // reset values
  localparam logic [31:0] RST_LOOP_CTRL = 32'h0000_0180;
  localparam logic [31:0] RST_PEAK_BW = 32'h0000_0004;
  localparam logic [31:0] RST_AMP_THR = 32'h0000_C040;
  localparam logic [31:0] RST_INTEG_BW = 32'h0000_0044;
  localparam logic [31:0] RST_GAIN_BOUNDS = 32'h0000_00F0;
  localparam logic [31:0] RST_OFFSET_WIN = 32'h0000_8878;
  localparam logic [31:0] RST_COMP_BOUNDS = 32'h0000_2060;
  // fixed points and limits
  localparam int HPF_FRAC = 11;
  localparam int DECAY_OFS = 6;
  localparam logic [5:0] ADC_TOP = 6'h3F;
  localparam logic [2:0] DIV_MIN = 3'h1;
  localparam logic [2:0] DIV_MAX = 3'h5;
  // noise filter and decay settings of one peak path
  typedef struct packed {
    logic [3:0] noise_bw;
    logic [3:0] decay_bw;
  } peak_cfg_t;
  // a maximum and minimum pair
  typedef struct packed {
    logic [7:0] mx;
    logic [7:0] mn;
  } peak_pair_t;
endpackage

/* File: logic/rf_signal_conditioning.sv */
// rf sample averaging, high-pass filter, peak detectors, gain/offset loops
`timescale 1ns/1ps
`default_nettype none
module rf_signal_conditioning
  import rf_cond_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // adc samples and defect hold
  input wire logic [5:0] adc_sample,
  input wire logic defect_hold,
  // conditioned stream
  output logic [7:0] hpf_out,
  output logic hpf_valid,
  // analog gain and offset steering
  output logic [3:0] coarse_gain,
  output logic [3:0] fine_gain,
  output logic [6:0] offset_comp_code,
  // decay peaks toward the defect detector
  output peak_pair_t defect_peaks
);

  // software registers
  logic [31:0] hpf_control_r, hpf_control_nxt;
  peak_cfg_t peak_bandwidth_cfg_r, peak_bandwidth_cfg_nxt;
  peak_cfg_t defect_peak_bw_cfg_r, defect_peak_bw_cfg_nxt;
  logic [31:0] gain_offset_loop_ctrl_r, gain_offset_loop_ctrl_nxt;
  logic [31:0] thr_r, thr_nxt, ibw_r, ibw_nxt, gbnd_r, gbnd_nxt;
  logic [31:0] owin_r, owin_nxt, cbnd_r, cbnd_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic setup, wr;
  logic [7:0] meas_amplitude, meas_offset;
  logic [8:0] meas_sum;
  peak_pair_t meas_peaks;

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr && paddr == ofs;
  endfunction

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign pready = penable;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign meas_sum = {1'b0, meas_peaks.mx} + {1'b0, meas_peaks.mn};
  assign meas_amplitude = meas_peaks.mx - meas_peaks.mn;
  assign meas_offset = meas_sum[8:1];

  // register writes and read mux, read data latched in setup
  always_comb begin
    hpf_control_nxt = hit(OFS_HPF_CONTROL) ? pwdata : hpf_control_r;
    peak_bandwidth_cfg_nxt = hit(OFS_PEAK_BW) ? pwdata[7:0]
                                              : peak_bandwidth_cfg_r;
    defect_peak_bw_cfg_nxt = hit(OFS_DEFECT_BW) ? pwdata[7:0]
                                                : defect_peak_bw_cfg_r;
    gain_offset_loop_ctrl_nxt = hit(OFS_LOOP_CTRL) ? pwdata
                                                   : gain_offset_loop_ctrl_r;
    thr_nxt = hit(OFS_AMP_THR) ? pwdata : thr_r;
    ibw_nxt = hit(OFS_INTEG_BW) ? pwdata : ibw_r;
    gbnd_nxt = hit(OFS_GAIN_BOUNDS) ? pwdata : gbnd_r;
    owin_nxt = hit(OFS_OFFSET_WIN) ? pwdata : owin_r;
    cbnd_nxt = hit(OFS_COMP_BOUNDS) ? pwdata : cbnd_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup) begin
      pslverr_nxt = 1'b0;
      unique case (paddr)
        OFS_HPF_CONTROL: prdata_nxt = {25'h0, hpf_control_r[6:0]};
        OFS_PEAK_BW: prdata_nxt = {24'h0, peak_bandwidth_cfg_r};
        OFS_DEFECT_BW: prdata_nxt = {24'h0, defect_peak_bw_cfg_r};
        OFS_LOOP_CTRL: prdata_nxt = {21'h0, gain_offset_loop_ctrl_r[10:0]};
        OFS_MAX_PEAK: prdata_nxt = {24'h0, meas_peaks.mx};
        OFS_MIN_PEAK: prdata_nxt = {24'h0, meas_peaks.mn};
        OFS_AMPLITUDE: prdata_nxt = {24'h0, meas_amplitude};
        OFS_OFFSET: prdata_nxt = {24'h0, meas_offset};
        OFS_GAIN: prdata_nxt = {24'h0, coarse_gain, fine_gain};
        OFS_AMP_THR: prdata_nxt = {16'h0, thr_r[15:0]};
        OFS_INTEG_BW: prdata_nxt = {24'h0, ibw_r[7:0]};
        OFS_GAIN_BOUNDS: prdata_nxt = {24'h0, gbnd_r[7:0]};
        OFS_OFFSET_COMP: prdata_nxt = {25'h0, offset_comp_code};
        OFS_OFFSET_WIN: prdata_nxt = {15'h0, owin_r[16:0]};
        OFS_COMP_BOUNDS: prdata_nxt = {17'h0, cbnd_r[14:0]};
        default: begin
          prdata_nxt = 32'h0000_0000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hpf_control_r <= 32'h0000_0000;
      peak_bandwidth_cfg_r <= RST_PEAK_BW[7:0];
      defect_peak_bw_cfg_r <= RST_PEAK_BW[7:0];
      gain_offset_loop_ctrl_r <= RST_LOOP_CTRL;
      thr_r <= RST_AMP_THR;
      ibw_r <= RST_INTEG_BW;
      gbnd_r <= RST_GAIN_BOUNDS;
      owin_r <= RST_OFFSET_WIN;
      cbnd_r <= RST_COMP_BOUNDS;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      hpf_control_r <= hpf_control_nxt;
      peak_bandwidth_cfg_r <= peak_bandwidth_cfg_nxt;
      defect_peak_bw_cfg_r <= defect_peak_bw_cfg_nxt;
      gain_offset_loop_ctrl_r <= gain_offset_loop_ctrl_nxt;
      thr_r <= thr_nxt;
      ibw_r <= ibw_nxt;
      gbnd_r <= gbnd_nxt;
      owin_r <= owin_nxt;
      cbnd_r <= cbnd_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // sample averager: one tick and one 8-bit value per 2^k samples
  logic [2:0] div_k;
  logic [4:0] cnt_r, cnt_nxt;
  logic [10:0] sum_r, sum_nxt, sum_all;
  logic [7:0] avg_r, avg_nxt;
  logic tick_r, tick_nxt;
  logic [12:0] sum_x4;
  assign div_k = (gain_offset_loop_ctrl_r[10:8] < DIV_MIN) ? DIV_MIN :
                 (gain_offset_loop_ctrl_r[10:8] > DIV_MAX) ? DIV_MAX :
                 gain_offset_loop_ctrl_r[10:8];
  assign sum_all = sum_r + {5'h0, adc_sample};
  assign sum_x4 = {sum_all, 2'b00} >> div_k;
  always_comb begin
    cnt_nxt = cnt_r + 5'h1;
    sum_nxt = sum_all;
    avg_nxt = avg_r;
    tick_nxt = 1'b0;
    if (cnt_r >= 5'((6'h1 << div_k) - 6'h1)) begin
      cnt_nxt = 5'h0;
      sum_nxt = 11'h000;
      avg_nxt = sum_x4[7:0];
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 5'h0;
      sum_r <= 11'h000;
      avg_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sum_r <= sum_nxt;
      avg_r <= avg_nxt;
      tick_r <= tick_nxt;
    end
  end

  // high-pass as input minus a low-pass held in 2^-11 units
  logic signed [19:0] lp_r, lp_nxt;
  logic signed [20:0] hp_err;
  logic signed [27:0] hp_prod;
  logic signed [9:0] hp_val;
  logic [7:0] hpf_out_r, hpf_out_nxt;
  logic hpf_valid_r, hpf_clr;
  assign hpf_clr = hpf_control_r[HPF_CLEAR_BIT];
  assign hp_err = {1'b0, avg_r, 11'h000} - {lp_r[19], lp_r};
  assign hp_prod = hp_err * $signed({1'b0, hpf_control_r[5:0]});
  assign hp_val = $signed({2'b00, avg_r}) - $signed(lp_r[19:HPF_FRAC]);
  always_comb begin
    lp_nxt = lp_r;
    hpf_out_nxt = hpf_out_r;
    if (hpf_clr) begin
      lp_nxt = 20'sh0;
      hpf_out_nxt = 8'h00;
    end else if (tick_r) begin
      if (!defect_hold)
        lp_nxt = lp_r + 20'($signed(hp_prod[27:HPF_FRAC]));
      if (hp_val > 10'sd127)
        hpf_out_nxt = 8'h7F;
      else if (hp_val < -10'sd128)
        hpf_out_nxt = 8'h80;
      else
        hpf_out_nxt = hp_val[7:0];
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lp_r <= 20'sh0;
      hpf_out_r <= 8'h00;
      hpf_valid_r <= 1'b0;
    end else begin
      lp_r <= lp_nxt;
      hpf_out_r <= hpf_out_nxt;
      hpf_valid_r <= tick_r;
    end
  end
  assign hpf_out = hpf_out_r;
  assign hpf_valid = hpf_valid_r;

  // decay peak detectors: 0 measurement, 1 defect path
  peak_cfg_t pcfg [2];
  logic [15:0] nf_r [2];
  logic [23:0] mx_r [2];
  logic [23:0] mn_r [2];
  assign pcfg[0] = peak_bandwidth_cfg_r;
  assign pcfg[1] = defect_peak_bw_cfg_r;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_decay
      logic [15:0] nf_nxt;
      logic [23:0] mx_nxt, mn_nxt;
      logic [7:0] x;
      logic [4:0] m;
      logic signed [16:0] d;
      assign m = 5'(pcfg[g].decay_bw) + 5'(DECAY_OFS);
      assign d = $signed({1'b0, avg_r, 8'h00}) - $signed({1'b0, nf_r[g]});
      assign x = (pcfg[g].noise_bw == 4'h0) ? avg_r : nf_r[g][15:8];
      always_comb begin
        nf_nxt = nf_r[g];
        mx_nxt = mx_r[g];
        mn_nxt = mn_r[g];
        if (tick_r) begin
          nf_nxt = nf_r[g] + 16'(d >>> pcfg[g].noise_bw);
          if (x >= mx_r[g][23:16])
            mx_nxt = {x, 16'h0000};
          else
            mx_nxt = mx_r[g] - (mx_r[g] >> m);
          if (x <= mn_r[g][23:16])
            mn_nxt = {x, 16'h0000};
          else
            mn_nxt = mn_r[g] + ((24'hFFFFFF - mn_r[g]) >> m);
        end
      end
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          nf_r[g] <= 16'h0000;
          mx_r[g] <= 24'h000000;
          mn_r[g] <= 24'hFFFFFF;
        end else begin
          nf_r[g] <= nf_nxt;
          mx_r[g] <= mx_nxt;
          mn_r[g] <= mn_nxt;
        end
      end
    end
  endgenerate
  assign meas_peaks = {mx_r[0][23:16], mn_r[0][23:16]};
  assign defect_peaks = {mx_r[1][23:16], mn_r[1][23:16]};

  // window peak detector over 2^n ticks, fed by the measurement noise filter
  logic [15:0] wcnt_r, wcnt_nxt;
  logic [7:0] wmx_r, wmx_nxt, wmn_r, wmn_nxt, wx;
  peak_pair_t win_r, win_nxt;
  logic clip_r, clip_nxt, wclip_r, wclip_nxt, wdone_r, wdone_nxt;
  logic [15:0] wlast;
  assign wx = (pcfg[0].noise_bw == 4'h0) ? avg_r : nf_r[0][15:8];
  assign wlast = 16'((17'h1 << gain_offset_loop_ctrl_r[7:4]) - 17'h1);
  always_comb begin
    wcnt_nxt = wcnt_r;
    wmx_nxt = wmx_r;
    wmn_nxt = wmn_r;
    win_nxt = win_r;
    wclip_nxt = wclip_r;
    wdone_nxt = 1'b0;
    clip_nxt = clip_r || adc_sample == ADC_TOP || adc_sample == 6'h00;
    if (tick_r) begin
      wmx_nxt = (wx > wmx_r) ? wx : wmx_r;
      wmn_nxt = (wx < wmn_r) ? wx : wmn_r;
      wcnt_nxt = wcnt_r + 16'h1;
      if (wcnt_r >= wlast) begin
        win_nxt = {wmx_nxt, wmn_nxt};
        wclip_nxt = clip_nxt;
        wdone_nxt = 1'b1;
        wcnt_nxt = 16'h0;
        wmx_nxt = 8'h00;
        wmn_nxt = 8'hFF;
        clip_nxt = 1'b0;
      end
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wcnt_r <= 16'h0;
      wmx_r <= 8'h00;
      wmn_r <= 8'hFF;
      win_r <= 16'h0000;
      clip_r <= 1'b0;
      wclip_r <= 1'b0;
      wdone_r <= 1'b0;
    end else begin
      wcnt_r <= wcnt_nxt;
      wmx_r <= wmx_nxt;
      wmn_r <= wmn_nxt;
      win_r <= win_nxt;
      clip_r <= clip_nxt;
      wclip_r <= wclip_nxt;
      wdone_r <= wdone_nxt;
    end
  end

  // gain and offset loops: integrate window requests, step past hysteresis
  logic [7:0] w_amp, w_off;
  logic [8:0] w_sum;
  logic g_up, g_dn, o_hi, o_lo, o_up, o_dn, inv;
  logic signed [15:0] gint_r, gint_nxt, oint_r, oint_nxt, gthr, othr;
  logic [3:0] fine_r, fine_nxt, coarse_r, coarse_nxt;
  logic signed [6:0] comp_r, comp_nxt, c_lo, c_hi;
  assign w_amp = win_r.mx - win_r.mn;
  assign w_sum = {1'b0, win_r.mx} + {1'b0, win_r.mn};
  assign w_off = w_sum[8:1];
  assign g_up = w_amp < thr_r[7:0];
  assign g_dn = w_amp > thr_r[15:8] || wclip_r;
  assign inv = owin_r[INV_BIT];
  assign o_hi = w_off > owin_r[15:8];
  assign o_lo = w_off < owin_r[7:0];
  assign o_dn = inv ? o_lo : o_hi;
  assign o_up = inv ? o_hi : o_lo;
  assign gthr = 16'sh1 <<< ibw_r[3:0];
  assign othr = 16'sh1 <<< ibw_r[7:4];
  assign c_lo = cbnd_r[6:0];
  assign c_hi = cbnd_r[14:8];
  always_comb begin
    gint_nxt = gint_r;
    oint_nxt = oint_r;
    fine_nxt = fine_r;
    coarse_nxt = coarse_r;
    comp_nxt = comp_r;
    if (wdone_r && gain_offset_loop_ctrl_r[0]) begin
      gint_nxt = gint_r + (g_dn ? -16'sh1 : g_up ? 16'sh1 : 16'sh0);
      if (gint_nxt >= gthr) begin
        gint_nxt = 16'sh0;
        if (fine_r < gbnd_r[7:4])
          fine_nxt = fine_r + 4'h1;
      end else if (gint_nxt <= -gthr) begin
        gint_nxt = 16'sh0;
        if (fine_r > gbnd_r[3:0])
          fine_nxt = fine_r - 4'h1;
      end
    end
    if (wdone_r && gain_offset_loop_ctrl_r[1]) begin
      oint_nxt = oint_r + (o_dn ? -16'sh1 : o_up ? 16'sh1 : 16'sh0);
      if (oint_nxt >= othr) begin
        oint_nxt = 16'sh0;
        if (comp_r < c_hi)
          comp_nxt = comp_r + 7'sd1;
      end else if (oint_nxt <= -othr) begin
        oint_nxt = 16'sh0;
        if (comp_r > c_lo)
          comp_nxt = comp_r - 7'sd1;
      end
    end
    if (hit(OFS_GAIN)) begin
      fine_nxt = pwdata[3:0];
      coarse_nxt = pwdata[7:4];
    end
    if (hit(OFS_OFFSET_COMP))
      comp_nxt = pwdata[6:0];
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gint_r <= 16'sh0;
      oint_r <= 16'sh0;
      fine_r <= 4'h0;
      coarse_r <= 4'h0;
      comp_r <= 7'sh0;
    end else begin
      gint_r <= gint_nxt;
      oint_r <= oint_nxt;
      fine_r <= fine_nxt;
      coarse_r <= coarse_nxt;
      comp_r <= comp_nxt;
    end
  end
  assign fine_gain = fine_r;
  assign coarse_gain = coarse_r;
  assign offset_comp_code = comp_r;

  // checks; the divider seen one cycle after a tick sets the next gap
  logic x_hi_meas;
  assign x_hi_meas = pcfg[0].noise_bw == 4'h0 && avg_r >= meas_peaks.mx;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_avg_tick_gap: assert property (
    tick_r ##1 div_k == DIV_MIN |-> !tick_r ##1 tick_r)
    else $error("averager tick spacing wrong");
  a_hpf_clear: assert property (
    hpf_clr |=> lp_r == 20'sh0 && hpf_out_r == 8'h00)
    else $error("high-pass state not cleared");
  a_hpf_hold: assert property (
    defect_hold && !hpf_clr |=> $stable(lp_r))
    else $error("low-pass moved during hold");
  a_max_attack: assert property (
    tick_r && x_hi_meas |=> meas_peaks.mx == $past(avg_r))
    else $error("max peak missed new extreme");
  a_win_pair: assert property (
    wdone_r |-> win_r.mx >= win_r.mn || win_r == 16'h00FF)
    else $error("window pair inverted");
  a_win_restart: assert property (
    wdone_nxt |=> wmx_r == 8'h00 && wmn_r == 8'hFF ##1 !wdone_r)
    else $error("window tracking not restarted");
  a_coarse_fixed: assert property (
    !hit(OFS_GAIN) |=> $stable(coarse_r))
    else $error("coarse gain changed by loop");
  a_fine_step: assert property (
    !$past(hit(OFS_GAIN)) && $changed(fine_r)
    |-> $past(wdone_r) && (fine_r == $past(fine_r) + 4'h1 ||
    fine_r == $past(fine_r) - 4'h1))
    else $error("fine gain jumped");
  a_comp_dir: assert property (
    !$past(hit(OFS_OFFSET_COMP)) && comp_r < $past(comp_r)
    |-> $past(o_dn))
    else $error("offset code lowered without cause");
  c_tick_k5: cover property (tick_r && div_k == DIV_MAX);
  c_fine_up: cover property (fine_r == $past(fine_r) + 4'h1);
  c_comp_dn: cover property (comp_r < $past(comp_r));
  c_hpf_clr: cover property ($rose(hpf_clr));

endmodule
`default_nettype wire

/* File: dv/rf_front_model.sv */
// analog front end model: gain and offset steer a square tone into the adc
`timescale 1ns/1ps
`default_nettype none
module rf_front_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // tone on or flat level, analog steering from the block
  input wire logic tone_en,
  input wire logic [3:0] fine_gain,
  input wire logic [6:0] offset_comp_code,
  // sampled code
  output logic [5:0] adc_sample
);
  logic [4:0] phase_r;
  int level;
  // swing of 4 plus fine gain about a level moved one code per offset step
  always_comb begin
    level = 40 + $signed(offset_comp_code);
    if (tone_en && phase_r[4]) begin
      level = level + 4 + int'(fine_gain);
    end else if (tone_en) begin
      level = level - 4 - int'(fine_gain);
    end
  end
  // the clamp stands in for adc clipping at both rails
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase_r <= 5'h00;
      adc_sample <= 6'h00;
    end else begin
      phase_r <= phase_r + 5'h01;
      adc_sample <= (level < 0) ? 6'h00 : (level > 63) ? 6'h3F : 6'(level);
    end
  end
endmodule
`default_nettype wire

/* File: dv/rf_signal_conditioning_tb_top.sv */
// self-checking bench for the rf signal conditioning block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_fail++; \
  $display("Error %s exp %0h got %0h", nm, ex, gt); end end
module rf_signal_conditioning_tb_top
  import rf_cond_pkg::*;
;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic x;
  } row_t;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, hpf_out;
  logic [31:0] pwdata, prdata, rdat;
  logic [5:0] adc_sample;
  logic defect_hold, tone_en, hpf_valid;
  logic [3:0] coarse_gain, fine_gain;
  logic [6:0] offset_comp_code;
  peak_pair_t defect_peaks;
  int n_fail, cmp_count, gap_n;
  // write then read back; unmapped place refuses
  row_t rows[7] = '{
    '{OFS_HPF_CONTROL, 32'h3F, 32'h3F, 1'b0},
    '{OFS_PEAK_BW, 32'h5A, 32'h5A, 1'b0},
    '{OFS_DEFECT_BW, 32'hA5, 32'hA5, 1'b0},
    '{OFS_GAIN, 32'h35, 32'h35, 1'b0},
    '{OFS_OFFSET_WIN, 32'h18878, 32'h18878, 1'b0},
    '{OFS_COMP_BOUNDS, 32'h7F7F, 32'h7F7F, 1'b0},
    '{8'h3C, 32'hFF, 32'h00, 1'b1}};
  // reset values
  row_t rst_rows[8] = '{
    '{OFS_LOOP_CTRL, 0, RST_LOOP_CTRL, 1'b0}, '{OFS_PEAK_BW, 0, RST_PEAK_BW, 1'b0},
    '{OFS_AMP_THR, 0, RST_AMP_THR, 1'b0}, '{OFS_INTEG_BW, 0, RST_INTEG_BW, 1'b0},
    '{OFS_GAIN_BOUNDS, 0, RST_GAIN_BOUNDS, 1'b0}, '{OFS_GAIN, 0, 0, 1'b0},
    '{OFS_OFFSET_WIN, 0, RST_OFFSET_WIN, 1'b0},
    '{OFS_COMP_BOUNDS, 0, RST_COMP_BOUNDS, 1'b0}};
  rf_signal_conditioning rf_signal_conditioning_i (.mclk(mclk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_sample(adc_sample), .defect_hold(defect_hold), .hpf_out(hpf_out),
    .hpf_valid(hpf_valid), .coarse_gain(coarse_gain), .fine_gain(fine_gain),
    .offset_comp_code(offset_comp_code), .defect_peaks(defect_peaks));
  rf_front_model rf_front_model_i (.mclk(mclk), .rstn(rstn), .tone_en(tone_en),
    .fine_gain(fine_gain), .offset_comp_code(offset_comp_code),
    .adc_sample(adc_sample));
  // apb master: setup, access held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // only the watchdog ends a wait for pready
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles between two conditioned samples
  task automatic gap(output int n);
    int t;
    t = 0;
    do begin @(posedge mclk); t++; end while (hpf_valid !== 1'b1 && t < 100);
    n = 0;
    do begin @(posedge mclk); n++; end while (hpf_valid !== 1'b1 && n < 100);
  endtask
  // magnitude of a signed sample
  function automatic logic [7:0] mag(input logic [7:0] v);
    return v[7] ? 8'h00 - v : v;
  endfunction
  task automatic give_verdict;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, defect_hold, tone_en} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    cmp_count = 0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      `CHK("reg read", rows[i].e, rdat)
      `CHK("reg error", rows[i].x, err)
    end
    `CHK("coarse port", 4'h3, coarse_gain)
    `CHK("fine port", 4'h5, fine_gain)
    // second reset in mid-run restores defaults
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rst_rows[i]) begin
      apb(1'b0, rst_rows[i].a, 32'h0);
      `CHK("reset value", rst_rows[i].e, rdat)
    end
    `CHK("reset fine", 4'h0, fine_gain)
    // one sample per 2^k adc samples for every division factor
    for (int k = 1; k <= 5; k++) begin
      apb(1'b1, OFS_LOOP_CTRL, 32'(k) << 8 | 32'h40);
      gap(gap_n);
      gap(gap_n);
      `CHK("tick gap", 1 << k, gap_n)
    end
    // gain loop under bounds, then both thresholds
    apb(1'b1, OFS_GAIN, 32'h30);
    apb(1'b1, OFS_GAIN_BOUNDS, 32'h20);
    // two like requests per step, so a window that still holds samples
    // from before the last step cannot step again
    apb(1'b1, OFS_INTEG_BW, 32'h11);
    apb(1'b1, OFS_LOOP_CTRL, 32'h141);
    tone_en <= 1'b1;
    repeat (3000) @(posedge mclk);
    `CHK("fine at bound", 4'h2, fine_gain)
    `CHK("coarse kept", 4'h3, coarse_gain)
    apb(1'b1, OFS_GAIN_BOUNDS, 32'h70);
    repeat (3000) @(posedge mclk);
    `CHK("fine raised", 4'h4, fine_gain)
    apb(1'b1, OFS_AMP_THR, 32'h3020);
    repeat (3000) @(posedge mclk);
    `CHK("fine lowered", 4'h2, fine_gain)
    apb(1'b0, OFS_GAIN, 32'h0);
    `CHK("fine readback", 32'h32, rdat)
    // offset loop settles at window edge, readback from decay detector
    apb(1'b1, OFS_LOOP_CTRL, 32'h142);
    repeat (3000) @(posedge mclk);
    `CHK("offset code", 7'h7A, offset_comp_code)
    apb(1'b0, OFS_AMPLITUDE, 32'h0);
    `CHK("amplitude", 1'b1, rdat[7:0] <= 8'd48 && rdat[7:0] >= 8'd40)
    apb(1'b0, OFS_OFFSET, 32'h0);
    `CHK("offset", 1'b1, rdat[7:0] <= 8'd136 && rdat[7:0] >= 8'd128)
    apb(1'b1, OFS_OFFSET_WIN, 32'h18878);
    apb(1'b1, OFS_OFFSET_COMP, 32'h0);
    repeat (3000) @(posedge mclk);
    `CHK("inverted bound", 7'h20, offset_comp_code)
    // high-pass removes a flat level, clear zeroes it, hold lets it through until released
    apb(1'b1, OFS_LOOP_CTRL, 32'h140);
    apb(1'b1, OFS_OFFSET_COMP, 32'h70);
    tone_en <= 1'b0;
    apb(1'b1, OFS_HPF_CONTROL, 32'h3F);
    repeat (2000) @(posedge mclk);
    `CHK("hpf settled", 1'b1, mag(hpf_out) <= 8'd4)
    apb(1'b1, OFS_HPF_CONTROL, 32'h7F);
    repeat (20) @(posedge mclk);
    `CHK("hpf cleared", 8'h00, hpf_out)
    defect_hold <= 1'b1;
    apb(1'b1, OFS_HPF_CONTROL, 32'h3F);
    repeat (400) @(posedge mclk);
    `CHK("hpf held", 1'b1, mag(hpf_out) > 8'd16)
    defect_hold <= 1'b0;
    repeat (2000) @(posedge mclk);
    `CHK("hpf released", 1'b1, mag(hpf_out) <= 8'd4)
    `CHK("defect peaks", 16'h6060, defect_peaks)
    give_verdict();
  end
endmodule
`default_nettype wire
